// ===== stmon_core.sv
`timescale 1ns/10ps
module stmon_core (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [15:0]          addr,
    input  wire logic [15:0]          wr_data,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic      [15:0]          rd_data,
    input  wire stmon_pkg::stmon_temp_t t_illum,
    input  wire stmon_pkg::stmon_temp_t t_sensor,
    input  wire stmon_pkg::stmon_temp_t t_comp,
    input  wire stmon_pkg::stmon_temp_t t_cpu,
    input  wire logic [15:0]          cpu_speed,
    input  wire logic                 cal_busy,
    input  wire logic                 cal_missing,
    input  wire logic                 factory_map,
    input  wire logic                 fw_restored,
    input  wire logic                 emitter_fault,
    input  wire logic                 cfg_fault,
    input  wire logic                 serdes_err,
    input  wire logic                 meta_err,
    input  wire logic                 frame_timeout,
    input  wire logic [47:0]          factory_mac,
    input  wire stmon_pkg::stmon_pix_t pix_in,
    output logic                      illum_drive,
    output logic                      illum_enable,
    output logic                      stream_enable,
    output logic                      cpu_throttle,
    output stmon_pkg::stmon_hdr_t     hdr_temps,
    output logic                      save_map,
    output logic                      companion_save,
    output logic                      clear_map,
    output logic      [47:0]          mac_active,
    output stmon_pkg::stmon_net_t     net_active,
    output logic      [15:0]          port_active,
    output logic      [31:0]          udp_dest,
    output stmon_pkg::stmon_pix_t     pix_out,
    output logic                      pix_invalid,
    output logic                      distance_ok
);
    // ******************************************
    // register writes
    // ******************************************
    logic [15:0]            mode_reg;
    logic [15:0]            fmt_reg;
    logic [6:0]             power_reg;
    logic [15:0]            trip_reg;
    logic [2:0]             out_mode_reg;
    logic [15:0]            mac_reg [3];
    logic                   mac_user_reg;
    logic [15:0]            ip_reg [6];
    logic                   clr_err;
    logic                   wr_cmd;
    stmon_pkg::stmon_ot_t   ot_reg;
    logic [31:0]            err_reg;
    logic [31:0]            err_set;
    logic [15:0]            st1;
    logic [15:0]            st2;
    logic [6:0]             pwm_cnt;

    assign clr_err = wr_stb && addr == stmon_pkg::A_MODE && wr_data[stmon_pkg::MODE_CLR];
    assign wr_cmd  = wr_stb && addr == stmon_pkg::A_CMD;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg     <= stmon_pkg::MODE_RST;
            fmt_reg      <= stmon_pkg::FMT_RST;
            power_reg    <= stmon_pkg::POWER_RST;
            trip_reg     <= stmon_pkg::TRIP_RST;
            out_mode_reg <= stmon_pkg::OUT_CM_AB;
        end else if (wr_stb) begin
            case (addr)
                // clear bit is never stored, so it reads back zero
                stmon_pkg::A_MODE: begin
                    mode_reg <= wr_data & ~(16'h0001 << stmon_pkg::MODE_CLR);
                end
                stmon_pkg::A_IMG_FMT: begin
                    fmt_reg <= wr_data;
                end
                stmon_pkg::A_POWER: begin
                    // out-of-range percentages saturate at full power
                    power_reg <= (wr_data > 16'(stmon_pkg::POWER_MAX)) ? stmon_pkg::POWER_MAX
                                                                       : wr_data[6:0];
                end
                stmon_pkg::A_TRIP: begin
                    trip_reg <= wr_data;
                end
                stmon_pkg::A_OUT_MODE: begin
                    out_mode_reg <= wr_data[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ******************************************
    // MAC and IP settings
    // ******************************************
    // user MAC lives only in volatile state; restoring it from flash is upstream
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mac_reg[0]   <= 16'h0000;
            mac_reg[1]   <= 16'h0000;
            mac_reg[2]   <= 16'h0000;
            mac_user_reg <= 1'b0;
        end else if (wr_cmd && wr_data == stmon_pkg::CMD_CLEAR) begin
            mac_user_reg <= 1'b0;
        end else if (wr_stb && addr >= stmon_pkg::A_MAC0 && addr < stmon_pkg::A_MAC0 + 16'h0003) begin
            mac_reg[2'(addr - stmon_pkg::A_MAC0)] <= wr_data;
            mac_user_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mac_active <= 48'h0000_0000_0000;
        end else begin
            mac_active <= mac_user_reg ? {mac_reg[0], mac_reg[1], mac_reg[2]} : factory_mac;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_ip
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ip_reg[gi] <= 16'h0000;
                end else if (wr_stb && addr == stmon_pkg::A_IP0 + 16'(gi)) begin
                    ip_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            net_active <= '0;
        end else if (wr_stb && addr == stmon_pkg::A_IP0 + 16'h0005) begin
            // staged words go live together with the last gateway word
            net_active <= {ip_reg[0], ip_reg[1], ip_reg[2], ip_reg[3], ip_reg[4], wr_data};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_active <= 16'h0000;
            udp_dest    <= 32'h0000_0000;
        end else if (wr_stb) begin
            if (addr == stmon_pkg::A_PORT) begin
                port_active <= wr_data;
            end
            if (addr == stmon_pkg::A_UDP0) begin
                udp_dest[31:16] <= wr_data;
            end
            if (addr == stmon_pkg::A_UDP0 + 16'h0001) begin
                udp_dest[15:0] <= wr_data;
            end
        end
    end

    // ******************************************
    // commands
    // ******************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            save_map       <= 1'b0;
            companion_save <= 1'b0;
            clear_map      <= 1'b0;
        end else begin
            save_map       <= wr_cmd && wr_data == stmon_pkg::CMD_SAVE;
            companion_save <= wr_cmd && wr_data == stmon_pkg::CMD_SAVE;
            clear_map      <= wr_cmd && wr_data == stmon_pkg::CMD_CLEAR;
        end
    end

    // ******************************************
    // temperatures
    // ******************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_temps <= '0;
        end else begin
            if (t_illum.valid) begin
                hdr_temps.illum <= t_illum.value;
            end
            if (t_sensor.valid) begin
                hdr_temps.sensor <= t_sensor.value;
            end
            if (t_comp.valid) begin
                hdr_temps.companion <= t_comp.value;
            end
        end
    end

    // signed compare so sub-zero readings never trip a non-negative threshold
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ot_reg <= stmon_pkg::STMON_OT_OK;
        end else if (t_illum.valid) begin
            case (ot_reg)
                stmon_pkg::STMON_OT_OK: begin
                    if ($signed(t_illum.value) > $signed(trip_reg)) begin
                        ot_reg <= stmon_pkg::STMON_OT_TRIP;
                    end
                end
                stmon_pkg::STMON_OT_TRIP: begin
                    if ($signed(t_illum.value) < $signed(trip_reg - stmon_pkg::HYST)) begin
                        ot_reg <= stmon_pkg::STMON_OT_OK;
                    end
                end
                default: begin
                    ot_reg <= stmon_pkg::STMON_OT_OK;
                end
            endcase
        end
    end

    logic [15:0] cpu_temp_reg;
    logic [15:0] cpu_speed_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_temp_reg  <= 16'h0000;
            cpu_speed_reg <= 16'h0000;
            cpu_throttle  <= 1'b0;
        end else begin
            cpu_speed_reg <= cpu_speed;
            if (t_cpu.valid) begin
                cpu_temp_reg <= t_cpu.value;
                cpu_throttle <= $signed(t_cpu.value) > $signed(stmon_pkg::CPU_HOT);
            end
        end
    end

    // ******************************************
    // illumination
    // ******************************************
    // 100-step pwm: duty equals the percentage, zero never drives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_cnt       <= 7'h00;
            illum_drive   <= 1'b0;
            illum_enable  <= 1'b0;
            stream_enable <= 1'b0;
        end else begin
            pwm_cnt       <= (pwm_cnt == stmon_pkg::POWER_MAX - 7'h01) ? 7'h00 : pwm_cnt + 7'h01;
            illum_enable  <= power_reg != 7'h00 && ot_reg == stmon_pkg::STMON_OT_OK;
            illum_drive   <= pwm_cnt < power_reg && ot_reg == stmon_pkg::STMON_OT_OK;
            stream_enable <= ot_reg == stmon_pkg::STMON_OT_OK;
        end
    end

    // ******************************************
    // flag words
    // ******************************************
    always_comb begin
        err_set = 32'h0000_0000;
        err_set[stmon_pkg::B_ILL_TERR]   = t_illum.fail;
        err_set[stmon_pkg::B_SEN_TERR]   = t_sensor.fail;
        err_set[stmon_pkg::B_CMP_TERR]   = t_comp.fail;
        err_set[stmon_pkg::B_ILL_ERR]    = emitter_fault;
        err_set[stmon_pkg::B_CFG_ERR]    = cfg_fault;
        err_set[16 + stmon_pkg::B_SERDES]  = serdes_err;
        err_set[16 + stmon_pkg::B_META]    = meta_err;
        err_set[16 + stmon_pkg::B_TIMEOUT] = frame_timeout;
        err_set[16 + stmon_pkg::B_CPU_HOT] = t_cpu.valid && $signed(t_cpu.value) > $signed(stmon_pkg::CPU_HOT);
    end

    generate
        for (gi = 0; gi < 32; gi++) begin : g_err
            if (stmon_pkg::ERR_MASK[gi]) begin : g_used
                // a new event in the clearing cycle survives
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        err_reg[gi] <= 1'b0;
                    end else begin
                        err_reg[gi] <= err_set[gi] | (err_reg[gi] & ~clr_err);
                    end
                end
            end else begin : g_unused
                assign err_reg[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        st1 = err_reg[15:0];
        st1[stmon_pkg::B_CAL_BUSY] = cal_busy;
        st1[stmon_pkg::B_CAL_MISS] = cal_missing;
        st1[stmon_pkg::B_FACTORY]  = factory_map;
        st1[stmon_pkg::B_FW_REST]  = fw_restored;
        st1[stmon_pkg::B_OVERTEMP] = ot_reg == stmon_pkg::STMON_OT_TRIP;
        st2 = err_reg[31:16];
    end

    // ******************************************
    // pixel invalidation
    // ******************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pix_out     <= '0;
            pix_invalid <= 1'b0;
            distance_ok <= 1'b0;
        end else begin
            pix_out     <= pix_in;
            pix_invalid <= pix_in.valid && pix_in.data[stmon_pkg::CM_BIT] &&
                           (out_mode_reg == stmon_pkg::OUT_CM_AB || out_mode_reg == stmon_pkg::OUT_CM_AVG);
            distance_ok <= out_mode_reg == stmon_pkg::OUT_CM_AB || out_mode_reg == stmon_pkg::OUT_AB;
        end
    end

    // ******************************************
    // register reads
    // ******************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 16'h0000;
        end else if (rd_stb) begin
            case (addr)
                stmon_pkg::A_MODE:      rd_data <= mode_reg;
                stmon_pkg::A_FLAGS1:    rd_data <= st1;
                stmon_pkg::A_IMG_FMT:   rd_data <= fmt_reg;
                stmon_pkg::A_POWER:     rd_data <= {9'h000, power_reg};
                stmon_pkg::A_TRIP:      rd_data <= trip_reg;
                stmon_pkg::A_T_ILLUM:   rd_data <= hdr_temps.illum;
                stmon_pkg::A_T_SENSOR:  rd_data <= hdr_temps.sensor;
                stmon_pkg::A_T_COMP:    rd_data <= hdr_temps.companion;
                stmon_pkg::A_CPU_TEMP:  rd_data <= cpu_temp_reg;
                stmon_pkg::A_CPU_SPEED: rd_data <= cpu_speed_reg;
                stmon_pkg::A_FLAGS2:    rd_data <= st2;
                stmon_pkg::A_OUT_MODE:  rd_data <= {13'h0000, out_mode_reg};
                stmon_pkg::A_PORT:      rd_data <= port_active;
                default: begin
                    if (addr >= stmon_pkg::A_MAC0 && addr < stmon_pkg::A_MAC0 + 16'h0003) begin
                        rd_data <= mac_active[16'(47 - 16 * (addr - stmon_pkg::A_MAC0)) -: 16];
                    end else if (addr >= stmon_pkg::A_IP0 && addr < stmon_pkg::A_IP0 + 16'h0006) begin
                        rd_data <= ip_reg[3'(addr - stmon_pkg::A_IP0)];
                    end else begin
                        rd_data <= 16'h0000;
                    end
                end
            endcase
        end else begin
            rd_data <= 16'h0000;
        end
    end

    // ******************************************
    // assertions
    // ******************************************
    a_zero_power_off: assert property (@(posedge clk) disable iff (!rst_b)
        power_reg == 7'h00 |=> !illum_enable && !illum_drive)
        else $error("illumination active at zero power");
    a_trip_stops: assert property (@(posedge clk) disable iff (!rst_b)
        ot_reg == stmon_pkg::STMON_OT_TRIP |=> !stream_enable && !illum_drive)
        else $error("streaming while over temperature");
    a_trip_enter: assert property (@(posedge clk) disable iff (!rst_b)
        ot_reg == stmon_pkg::STMON_OT_OK && t_illum.valid && $signed(t_illum.value) > $signed(trip_reg)
        |=> ot_reg == stmon_pkg::STMON_OT_TRIP)
        else $error("over temperature not entered");
    a_trip_hold: assert property (@(posedge clk) disable iff (!rst_b)
        ot_reg == stmon_pkg::STMON_OT_TRIP && $signed(t_illum.value) >= $signed(trip_reg - stmon_pkg::HYST)
        |=> ot_reg == stmon_pkg::STMON_OT_TRIP)
        else $error("left over temperature too early");
    a_flag9_track: assert property (@(posedge clk) disable iff (!rst_b)
        rd_stb && addr == stmon_pkg::A_FLAGS1 |=> rd_data[stmon_pkg::B_OVERTEMP] == $past(ot_reg[1]))
        else $error("overtemp flag mismatch");
    a_err_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        t_illum.fail ##1 !clr_err[*3] |-> st1[stmon_pkg::B_ILL_TERR])
        else $error("error flag lost");
    a_err_clear: assert property (@(posedge clk) disable iff (!rst_b)
        clr_err && err_set == 32'h0000_0000 |=> err_reg == 32'h0000_0000 && !mode_reg[stmon_pkg::MODE_CLR])
        else $error("errors not cleared");
    a_save_pair: assert property (@(posedge clk) disable iff (!rst_b)
        wr_cmd && wr_data == stmon_pkg::CMD_SAVE |=> save_map && companion_save ##1 !save_map)
        else $error("save pulse wrong");
    a_gw_commit: assert property (@(posedge clk) disable iff (!rst_b)
        !(wr_stb && addr == stmon_pkg::A_IP0 + 16'h0005) |=> $stable(net_active))
        else $error("ip changed without gateway write");
    a_cpu_hot: assert property (@(posedge clk) disable iff (!rst_b)
        t_cpu.valid && $signed(t_cpu.value) > $signed(stmon_pkg::CPU_HOT)
        |=> cpu_throttle && err_reg[16 + stmon_pkg::B_CPU_HOT])
        else $error("hot processor not handled");
endmodule // stmon_core

// ===== stmon_pkg.sv
package stmon_pkg;
    // ******************************************
    // register map
    // ******************************************
    localparam logic [15:0] A_MODE      = 16'h0001;
    localparam logic [15:0] A_FLAGS1    = 16'h0003;
    localparam logic [15:0] A_IMG_FMT   = 16'h0004;
    localparam logic [15:0] A_POWER     = 16'h0010;
    localparam logic [15:0] A_TRIP      = 16'h0011;
    localparam logic [15:0] A_T_ILLUM   = 16'h0012;
    localparam logic [15:0] A_T_SENSOR  = 16'h0013;
    localparam logic [15:0] A_T_COMP    = 16'h0014;
    localparam logic [15:0] A_CPU_TEMP  = 16'h0015;
    localparam logic [15:0] A_CPU_SPEED = 16'h0016;
    localparam logic [15:0] A_FLAGS2    = 16'h0017;
    localparam logic [15:0] A_CMD       = 16'h0018;
    localparam logic [15:0] A_MAC0      = 16'h0019;
    localparam logic [15:0] A_IP0       = 16'h0020;
    localparam logic [15:0] A_PORT      = 16'h0026;
    localparam logic [15:0] A_UDP0      = 16'h0027;
    localparam logic [15:0] A_OUT_MODE  = 16'h0029;
    // ******************************************
    // reset values and fields
    // ******************************************
    localparam logic [15:0] MODE_RST    = 16'h0001;
    localparam logic [15:0] FMT_RST     = 16'h0000;
    localparam logic [6:0]  POWER_RST   = 7'h64;
    localparam logic [6:0]  POWER_MAX   = 7'h64;
    localparam logic [15:0] TRIP_RST    = 16'h0046;
    localparam logic [15:0] HYST        = 16'h0002;
    localparam logic [15:0] CPU_HOT     = 16'h0050;
    localparam logic [15:0] CMD_SAVE    = 16'h0001;
    localparam logic [15:0] CMD_CLEAR   = 16'h0002;
    localparam int          MODE_CLR    = 6;
    localparam int          B_CAL_BUSY  = 2;
    localparam int          B_ILL_TERR  = 3;
    localparam int          B_SEN_TERR  = 4;
    localparam int          B_CAL_MISS  = 5;
    localparam int          B_FACTORY   = 6;
    localparam int          B_FW_REST   = 8;
    localparam int          B_OVERTEMP  = 9;
    localparam int          B_ILL_ERR   = 11;
    localparam int          B_CMP_TERR  = 14;
    localparam int          B_CFG_ERR   = 15;
    localparam int          B_SERDES    = 0;
    localparam int          B_META      = 1;
    localparam int          B_TIMEOUT   = 2;
    localparam int          B_CPU_HOT   = 3;
    localparam logic [31:0] ERR_MASK    = 32'h000F_C818;
    localparam int          CM_BIT      = 11;
    localparam logic [2:0]  OUT_CM_AB   = 3'h0;
    localparam logic [2:0]  OUT_AB      = 3'h1;
    localparam logic [2:0]  OUT_CM_AVG  = 3'h2;
    // ******************************************
    // types
    // ******************************************
    typedef struct packed {
        logic        valid;
        logic        fail;
        logic [15:0] value;
    } stmon_temp_t;
    typedef struct packed {
        logic [15:0] illum;
        logic [15:0] sensor;
        logic [15:0] companion;
    } stmon_hdr_t;
    typedef struct packed {
        logic [31:0] ip;
        logic [31:0] mask;
        logic [31:0] gw;
    } stmon_net_t;
    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } stmon_pix_t;
    typedef enum logic [1:0] {
        STMON_OT_OK   = 2'b01,
        STMON_OT_TRIP = 2'b10
    } stmon_ot_t;
endpackage

// ===== test_stmon_core.sv
`timescale 1ns/10ps
module test_stmon_core;
    // ****************************************
    // stimulus, expected-read queue, checks
    // ****************************************
    logic                   clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, rd_p = 1'b0;
    logic [15:0]            addr = 16'h0000, wr_data = 16'h0000, rd_data, seed = 16'h004E, spd = 16'h0000, se, q[$];
    logic [3:0]             sts = 4'h0;
    logic [4:0]             err = 5'h00;
    logic [47:0]            fmac = 48'h0000_0000_0A5E, mac;
    stmon_pkg::stmon_temp_t ts [4] = '{default: '0};
    stmon_pkg::stmon_pix_t  pix = '0;
    stmon_pkg::stmon_hdr_t  hdr;
    stmon_pkg::stmon_net_t  net;
    logic                   ill_en, str_en, thr, sv, csv, drv, cmap, pinv, dok;
    logic [31:0]            udp;
    stmon_pkg::stmon_pix_t  pout;
    logic [15:0]            prt, tv [5] = '{16'h0047, 16'h0044, 16'h0043, 16'h0033, 16'h002F};
    logic                   ok [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    int                     bad_count = 0, cmp_count = 0, dn = 0, k;
    always #10 clk = ~clk;
    stmon_core u_stmon_core (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .t_illum(ts[0]), .t_sensor(ts[1]), .t_comp(ts[2]), .t_cpu(ts[3]),
        .cpu_speed(spd), .cal_busy(sts[0]), .cal_missing(sts[1]), .factory_map(sts[2]), .fw_restored(sts[3]),
        .emitter_fault(err[0]), .cfg_fault(err[1]), .serdes_err(err[2]), .meta_err(err[3]),
        .frame_timeout(err[4]), .factory_mac(fmac), .pix_in(pix), .illum_drive(drv), .illum_enable(ill_en),
        .stream_enable(str_en), .cpu_throttle(thr), .hdr_temps(hdr), .save_map(sv), .companion_save(csv),
        .clear_map(cmap), .mac_active(mac), .net_active(net), .port_active(prt), .udp_dest(udp), .pix_out(pout),
        .pix_invalid(pinv), .distance_ok(dok));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        q.push_back(e);
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask
    task automatic w2;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic smp(input int w, input logic f, input logic [15:0] v);
        @(posedge clk);
        ts[w] <= {~f, f, v};
        @(posedge clk);
        ts[w] <= '0;
        w2();
    endtask
    always @(posedge clk) rd_p <= rd_stb;
    always @(posedge clk) dn <= dn + drv;
    always @(negedge clk) if (rd_p) chk("rd_data", rd_data, q.pop_front());
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(stmon_pkg::A_POWER, 16'h0064);
        rd(stmon_pkg::A_TRIP, 16'h0046);
        chk("mac", mac[15:0], fmac[15:0]);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            sts <= seed[3:0];
            pix <= seed[12:0];
            spd <= seed;
            se = {7'h00, seed[3], 1'b0, seed[2], seed[1], 2'h0, seed[0], 2'h0};
            w2();
            chk("pixinv", pinv, seed[12] & seed[11]);
            chk("dist", dok, 1'b1);
            rd(stmon_pkg::A_FLAGS1, se);
            rd(stmon_pkg::A_CPU_SPEED, seed);
        end
        for (int w = 0; w < 3; w++) smp(w, 1'b1, 16'h0000);
        smp(3, 1'b0, 16'h0051);
        @(posedge clk);
        err <= 5'h1F;
        @(posedge clk);
        err <= 5'h00;
        rd(stmon_pkg::A_FLAGS1, se | stmon_pkg::ERR_MASK[15:0]);
        rd(stmon_pkg::A_FLAGS2, stmon_pkg::ERR_MASK[31:16]);
        rd(stmon_pkg::A_CPU_TEMP, 16'h0051);
        chk("throttle", thr, 1'b1);
        wr(stmon_pkg::A_MODE, 16'h0041);
        rd(stmon_pkg::A_MODE, stmon_pkg::MODE_RST);
        rd(stmon_pkg::A_FLAGS1, se);
        rd(stmon_pkg::A_FLAGS2, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            if (i == 3) wr(stmon_pkg::A_TRIP, 16'h0032);
            smp(0, 1'b0, tv[i]);
            chk("stream", str_en, ok[i]);
            chk("illum", ill_en, ok[i]);
            chk("hdr", hdr.illum, tv[i]);
            rd(stmon_pkg::A_FLAGS1, se | {6'h00, ~ok[i], 9'h000});
        end
        rd(stmon_pkg::A_T_ILLUM, 16'h002F);
        for (int w = 1; w < 3; w++) begin
            smp(w, 1'b0, 16'h0020 + 16'(w));
            chk("hdr", w == 1 ? hdr.sensor : hdr.companion, 16'h0020 + 16'(w));
            rd(stmon_pkg::A_T_SENSOR + 16'(w - 1), 16'h0020 + 16'(w));
        end
        wr(stmon_pkg::A_POWER, 16'h0000);
        w2();
        chk("illum", ill_en, 1'b0);
        wr(stmon_pkg::A_POWER, 16'h00C8);
        rd(stmon_pkg::A_POWER, 16'h0064);
        w2();
        chk("illum", ill_en, 1'b1);
        wr(stmon_pkg::A_POWER, 16'h0028);
        w2();
        k = dn;
        repeat (100) @(posedge clk);
        @(negedge clk);
        chk("pwm", 16'(dn - k), 16'h0028);
        @(posedge clk);
        pix <= 13'h1800;
        wr(stmon_pkg::A_OUT_MODE, 16'(stmon_pkg::OUT_AB));
        w2();
        chk("pixinv", pinv, 1'b0);
        chk("dist", dok, 1'b1);
        wr(stmon_pkg::A_OUT_MODE, 16'(stmon_pkg::OUT_CM_AVG));
        w2();
        chk("pixinv", pinv, 1'b1);
        chk("dist", dok, 1'b0);
        wr(stmon_pkg::A_CMD, stmon_pkg::CMD_SAVE);
        @(negedge clk);
        chk("save", {sv, csv}, 2'b11);
        wr(stmon_pkg::A_IP0, 16'h0A0B);
        @(negedge clk);
        chk("ip", net.ip[31:16], 16'h0000);
        wr(stmon_pkg::A_IP0 + 16'h0005, 16'h0001);
        w2();
        chk("ip", net.ip[31:16], 16'h0A0B);
        wr(stmon_pkg::A_PORT, 16'h1F90);
        @(negedge clk);
        chk("port", prt, 16'h1F90);
        wr(stmon_pkg::A_UDP0 + 16'h0001, 16'h5678);
        @(negedge clk);
        chk("udp", udp[15:0], 16'h5678);
        wr(stmon_pkg::A_MAC0 + 16'h0002, 16'hBEEF);
        rd(stmon_pkg::A_MAC0 + 16'h0002, 16'hBEEF);
        wr(stmon_pkg::A_CMD, stmon_pkg::CMD_CLEAR);
        @(negedge clk);
        chk("clear", cmap, 1'b1);
        w2();
        chk("mac", mac[15:0], fmac[15:0]);
        wr(stmon_pkg::A_FLAGS2, 16'hFFFF);
        rd(stmon_pkg::A_FLAGS2, 16'h0000);
        rd(16'h00FF, 16'h0000);
        w2();
        end_of_test();
    end
endmodule // test_stmon_core
